// ==== rtl/hbrp_dev.sv ====
`timescale 1ns/1ps
`include "hbrp_map.svh"
module hbrp_dev (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // Host bus pins
    hbrp_if.dev              hb,
    // Core supply above power-on threshold
    input  wire logic        por_ok_i,
    // Status to core logic
    output logic             clk_stable_o,
    output logic             swrst_o,
    output logic             wr_stb_o,
    output logic [7:0]       wr_addr_o
);
    import hbrp_pkg::*;

    localparam int LOCK_CYC = `HBRP_LOCK_CYC;

    logic [28:0]            s1_q;
    logic [28:0]            s2_q;
    hbrp_dst_type           st_q;
    hbrp_dst_type           st_d;
    logic [15:0]            mem_q [`HBRP_NUM_REGS];
    logic [15:0]            mem_d [`HBRP_NUM_REGS];
    logic [15:0]            dout_q;
    logic [15:0]            dout_d;
    logic                   doe_q;
    logic                   doe_d;
    logic [15:0]            wbuf_q;
    logic [15:0]            wbuf_d;
    logic [7:0]             waddr_q;
    logic [7:0]             waddr_d;
    logic [1:0]             lock_q;
    logic [1:0]             lock_d;
    logic                   stable_q;
    logic                   stable_d;
    logic                   swrst_q;
    logic                   swrst_d;
    logic                   wstb_q;
    logic                   wstb_d;
    logic                   in_rst;
    logic [7:0]             addr_s;
    logic [15:0]            data_s;
    hbrp_cyc_type           kind;

    // Two-flop synchroniser for every pin; only s2_q is read
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_q <= `HBRP_SY_RST;
            s2_q <= `HBRP_SY_RST;
        end
        else if (ce_i)
        begin
            s1_q <= {por_ok_i, hb.reset_n, hb.cs_n, hb.rd_n, hb.wr_n,
                     hb.adrs, hb.data};
            s2_q <= s1_q;
        end
    end

    // Decoded, synchronised bus view
    assign addr_s = s2_q[`HBRP_SY_ADDR_LSB +: 8];
    assign data_s = s2_q[15:0];
    assign kind   = hbrp_cyc_f(s2_q[`HBRP_SY_CS], s2_q[`HBRP_SY_RD],
                               s2_q[`HBRP_SY_WR]);
    assign in_rst = !s2_q[`HBRP_SY_POR] || !s2_q[`HBRP_SY_HWRST];

    // Next-state logic for reset sequencing, bus cycles and registers
    always_comb
    begin
        st_d     = st_q;
        mem_d    = mem_q;
        dout_d   = dout_q;
        doe_d    = doe_q;
        wbuf_d   = wbuf_q;
        waddr_d  = waddr_q;
        lock_d   = lock_q;
        stable_d = stable_q;
        swrst_d  = 1'b0;
        wstb_d   = 1'b0;
        if (in_rst)
        begin
            // Supply low or pin asserted: lock restarts, reset bit cleared
            lock_d   = 2'h0;
            stable_d = 1'b0;
            mem_d[`HBRP_SWCTL_ADDR][`HBRP_SWCTL_RST_BIT] = 1'b0;
            st_d     = HBRP_D_IDLE;
            doe_d    = 1'b0;
        end
        else
        begin
            // Lock wait stands in for the reference-fed PLL settling
            if (!stable_q)
            begin
                if (lock_q == 2'(LOCK_CYC - 1))
                    stable_d = 1'b1;
                else
                    lock_d = lock_q + 2'h1;
            end
            // Reset bit set last cycle: defaults now, bit reads zero;
            // a commit decoded below in this same cycle still lands
            if (swrst_q)
            begin
                for (int i = 0; i < `HBRP_NUM_REGS; i++)
                    mem_d[i] = `HBRP_REG_DEFAULT;
            end
            case (st_q)
                HBRP_D_IDLE:
                begin
                    // Bus is ignored until the clocks count as stable
                    if (stable_q && kind == HBRP_CYC_READ)
                    begin
                        st_d   = HBRP_D_READ;
                        dout_d = mem_q[addr_s];
                        doe_d  = 1'b1;
                    end
                    else if (stable_q && kind == HBRP_CYC_WRITE)
                    begin
                        st_d    = HBRP_D_WRITE;
                        wbuf_d  = data_s;
                        waddr_d = addr_s;
                    end
                end
                HBRP_D_READ:
                begin
                    if (kind != HBRP_CYC_READ)
                    begin
                        st_d  = HBRP_D_IDLE;
                        doe_d = 1'b0;
                    end
                    else
                        dout_d = mem_q[addr_s];
                end
                HBRP_D_WRITE:
                begin
                    // Keep the last value seen while the strobes were low,
                    // since data may change as the strobe rises
                    if (kind == HBRP_CYC_WRITE)
                    begin
                        wbuf_d  = data_s;
                        waddr_d = addr_s;
                    end
                    else
                    begin
                        // One commit per strobe pair, then back to idle
                        st_d            = HBRP_D_IDLE;
                        mem_d[waddr_q]  = wbuf_q;
                        wstb_d          = 1'b1;
                        if (waddr_q == `HBRP_SWCTL_ADDR &&
                            wbuf_q[`HBRP_SWCTL_RST_BIT])
                            swrst_d = 1'b1;
                    end
                end
                default:
                begin
                    st_d  = HBRP_D_IDLE;
                    doe_d = 1'b0;
                end
            endcase
        end
    end

    // State registers, frozen while the clock enable is low
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q     <= HBRP_D_IDLE;
            for (int i = 0; i < `HBRP_NUM_REGS; i++)
                mem_q[i] <= `HBRP_REG_DEFAULT;
            dout_q   <= 16'h0000;
            doe_q    <= 1'b0;
            wbuf_q   <= 16'h0000;
            waddr_q  <= 8'h00;
            lock_q   <= 2'h0;
            stable_q <= 1'b0;
            swrst_q  <= 1'b0;
            wstb_q   <= 1'b0;
        end
        else if (ce_i)
        begin
            st_q     <= st_d;
            mem_q    <= mem_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
            wbuf_q   <= wbuf_d;
            waddr_q  <= waddr_d;
            lock_q   <= lock_d;
            stable_q <= stable_d;
            swrst_q  <= swrst_d;
            wstb_q   <= wstb_d;
        end
    end

    // Pin and status outputs, all from flops
    assign hb.dev_dout  = dout_q;
    assign hb.dev_doe   = doe_q;
    assign clk_stable_o = stable_q;
    assign swrst_o      = swrst_q;
    assign wr_stb_o     = wstb_q;
    assign wr_addr_o    = waddr_q;

endmodule // hbrp_dev

// ==== rtl/hbrp_map.svh ====
`ifndef HBRP_MAP_SVH
`define HBRP_MAP_SVH

// Bus widths and register count
`define HBRP_ADDR_W        8
`define HBRP_DATA_W        16
`define HBRP_NUM_REGS      256

// Switch control register and its self-clearing reset bit, register default and idle bus value
`define HBRP_SWCTL_ADDR    8'h20
`define HBRP_SWCTL_RST_BIT 0
`define HBRP_REG_DEFAULT   16'h0000
`define HBRP_BUS_IDLE      16'hffff

// Timing
`define HBRP_CLK_PERIOD_NS 50
`define HBRP_REF_CLK_MHZ   25
`define HBRP_LOCK_NS       60
`define HBRP_HWRST_NS      20
`define HBRP_WR_NS         50
`define HBRP_DEAD_NS       40
`define HBRP_LOCK_CYC  ((`HBRP_LOCK_NS+`HBRP_CLK_PERIOD_NS-1)/`HBRP_CLK_PERIOD_NS)
`define HBRP_HWRST_CYC ((`HBRP_HWRST_NS+`HBRP_CLK_PERIOD_NS-1)/`HBRP_CLK_PERIOD_NS)
`define HBRP_HOST_STROBE_CYC 8
`define HBRP_HOST_DEAD_CYC   4

// Synchroniser vector layout and reset value (strobes idle high)
`define HBRP_SY_POR        28
`define HBRP_SY_HWRST      27
`define HBRP_SY_CS         26
`define HBRP_SY_RD         25
`define HBRP_SY_WR         24
`define HBRP_SY_ADDR_LSB   16
`define HBRP_SY_RST        29'h0f000000

`endif

// ==== rtl/hbrp_pkg.sv ====
package hbrp_pkg;

    // Kind of bus cycle seen on the strobes
    typedef enum logic [1:0] {
        HBRP_CYC_NONE  = 2'b00,
        HBRP_CYC_READ  = 2'b01,
        HBRP_CYC_WRITE = 2'b10,
        HBRP_CYC_BAD   = 2'b11
    } hbrp_cyc_type;

    typedef enum logic [1:0] {
        HBRP_D_IDLE  = 2'b00,
        HBRP_D_READ  = 2'b01,
        HBRP_D_WRITE = 2'b10
    } hbrp_dst_type;

    typedef enum logic [1:0] {
        HBRP_H_IDLE   = 2'b00,
        HBRP_H_STROBE = 2'b01,
        HBRP_H_DEAD   = 2'b10,
        HBRP_H_RESET  = 2'b11
    } hbrp_hst_type;

    // Both strobes low together counts as neither cycle
    function automatic hbrp_cyc_type hbrp_cyc_f(input logic cs_n,
        input logic rd_n, input logic wr_n);
        if (cs_n)
            return HBRP_CYC_NONE;
        else if (!rd_n && !wr_n)
            return HBRP_CYC_BAD;
        else if (!rd_n)
            return HBRP_CYC_READ;
        else if (!wr_n)
            return HBRP_CYC_WRITE;
        else
            return HBRP_CYC_NONE;
    endfunction

endpackage

// ==== rtl/hbrp_if.sv ====
`timescale 1ns/1ps
`include "hbrp_map.svh"
interface hbrp_if;
    logic [7:0]  adrs;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        reset_n;
    logic        test;
    logic [15:0] host_dout;
    logic        host_doe;
    logic [15:0] dev_dout;
    logic        dev_doe;
    logic [15:0] data;

    // Shared data wire: pulled high when nobody drives
    assign data = dev_doe ? dev_dout :
                  host_doe ? host_dout : `HBRP_BUS_IDLE;

    modport dev (input adrs, cs_n, rd_n, wr_n, reset_n, data,
                 output dev_dout, dev_doe);
    modport host (input data,
                  output adrs, cs_n, rd_n, wr_n, reset_n, test,
                  host_dout, host_doe);
endinterface

// ==== rtl/hbrp_host.sv ====
`timescale 1ns/1ps
`include "hbrp_map.svh"
module hbrp_host (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // Host bus pins
    hbrp_if.host             hb,
    // User command port
    input  wire logic        req_i,
    input  wire logic        req_wr_i,
    input  wire logic [7:0]  req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    input  wire logic        hwrst_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [15:0]      rdata_o
);
    import hbrp_pkg::*;

    localparam int STB_CYC  = `HBRP_HOST_STROBE_CYC;
    localparam int DEAD_CYC = `HBRP_HOST_DEAD_CYC;
    localparam int RST_CYC  = `HBRP_HWRST_CYC;

    hbrp_hst_type st_q, st_d;
    logic [3:0]   cnt_q, cnt_d;
    logic [15:0]  d1_q, d2_q;
    logic [7:0]   adr_q, adr_d;
    logic [15:0]  wd_q, wd_d;
    logic         cs_q, cs_d, rd_q, rd_d, wr_q, wr_d;
    logic         oe_q, oe_d, rst_q, rst_d;
    logic         busy_q, busy_d, done_q, done_d;
    logic [15:0]  rdat_q, rdat_d;
    logic         test_q;

    // Read data crosses in from the pins through two flops
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            d1_q <= 16'h0000;
            d2_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            d1_q <= hb.data;
            d2_q <= d1_q;
        end
    end

    // Strobe sequencer; timings cover the device's sync latency
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        adr_d = adr_q;
        wd_d = wd_q;
        cs_d = cs_q;
        rd_d = rd_q;
        wr_d = wr_q;
        oe_d = oe_q;
        rst_d = rst_q;
        busy_d = busy_q;
        done_d = 1'b0;
        rdat_d = rdat_q;
        case (st_q)
            HBRP_H_IDLE:
            begin
                cnt_d = 4'h0;
                if (hwrst_i)
                begin
                    st_d = HBRP_H_RESET;
                    rst_d = 1'b0;
                    busy_d = 1'b1;
                end
                else if (req_i)
                begin
                    st_d = HBRP_H_STROBE;
                    adr_d = req_addr_i;
                    wd_d = req_wdata_i;
                    cs_d = 1'b0;
                    rd_d = req_wr_i;
                    wr_d = !req_wr_i;
                    oe_d = req_wr_i;
                    busy_d = 1'b1;
                end
            end
            HBRP_H_STROBE:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(STB_CYC - 1))
                begin
                    st_d = HBRP_H_DEAD;
                    cnt_d = 4'h0;
                    if (!rd_q)
                        rdat_d = d2_q;
                    cs_d = 1'b1;
                    rd_d = 1'b1;
                    wr_d = 1'b1;
                end
            end
            HBRP_H_DEAD:
            begin
                // Address and write data held until the device has seen the end
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(DEAD_CYC - 1))
                begin
                    st_d = HBRP_H_IDLE;
                    oe_d = 1'b0;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            HBRP_H_RESET:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(RST_CYC - 1))
                begin
                    st_d = HBRP_H_IDLE;
                    rst_d = 1'b1;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            default:
                st_d = HBRP_H_IDLE;
        endcase
    end

    // Registers; the test pin flop never leaves its low reset value
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q <= HBRP_H_IDLE;
            cnt_q <= 4'h0;
            adr_q <= 8'h00;
            wd_q <= 16'h0000;
            cs_q <= 1'b1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            oe_q <= 1'b0;
            rst_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdat_q <= 16'h0000;
            test_q <= 1'b0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            adr_q <= adr_d;
            wd_q <= wd_d;
            cs_q <= cs_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            oe_q <= oe_d;
            rst_q <= rst_d;
            busy_q <= busy_d;
            done_q <= done_d;
            rdat_q <= rdat_d;
            test_q <= 1'b0;
        end
    end

    // Pin and user outputs
    assign hb.adrs      = adr_q;
    assign hb.cs_n      = cs_q;
    assign hb.rd_n      = rd_q;
    assign hb.wr_n      = wr_q;
    assign hb.reset_n   = rst_q;
    assign hb.test      = test_q;
    assign hb.host_dout = wd_q;
    assign hb.host_doe  = oe_q;
    assign busy_o       = busy_q;
    assign done_o       = done_q;
    assign rdata_o      = rdat_q;

endmodule // hbrp_host

// ==== sim/hbrp_checker.sv ====
`timescale 1ns/1ps
`include "hbrp_map.svh"
module hbrp_checker (
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    // Host pins
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       reset_n,
    input wire logic       host_doe,
    input wire logic       dev_doe,
    // Device status
    input wire logic       clk_stable_o,
    input wire logic       swrst_o,
    input wire logic       wr_stb_o,
    input wire logic [7:0] wr_addr_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    // Read held long enough to pass the two-flop synchroniser
    sequence s_rd_held;
        (clk_stable_o && !cs_n && !rd_n && wr_n)[*4];
    endsequence
    // Write held, then ended by either strobe rising
    sequence s_wr_end;
        (clk_stable_o && !cs_n && !wr_n && rd_n)[*3]
        ##1 (clk_stable_o && (cs_n || wr_n));
    endsequence

    AST_RD_DRIVE: assert property (s_rd_held |-> dev_doe)
        else $error("Read cycle not answered on the bus");
    AST_RD_RELEASE: assert property ((cs_n || rd_n)[*4] |-> !dev_doe)
        else $error("Data bus still driven after read end");
    AST_WR_NO_DRIVE: assert property (!cs_n && !wr_n |-> !dev_doe)
        else $error("Device drives the bus during a write");
    AST_NO_CONTEND: assert property (dev_doe |-> !host_doe)
        else $error("Both ends drive the data bus");
    AST_WR_COMMIT: assert property (s_wr_end |-> ##[1:3] wr_stb_o)
        else $error("Write cycle not committed");
    AST_WR_IDLE: assert property ((cs_n || wr_n)[*5] |-> !wr_stb_o)
        else $error("Commit without a write cycle");
    AST_WR_ONCE: assert property (wr_stb_o |=> (!wr_stb_o)[*4])
        else $error("One write committed twice");
    AST_SWRST_PULSE: assert property (swrst_o |=> !swrst_o)
        else $error("Soft reset bit did not clear itself");
    // The reset pulse rises on the very edge that commits the control write
    AST_SWRST_CAUSE: assert property (swrst_o |-> wr_stb_o
        && wr_addr_o == `HBRP_SWCTL_ADDR)
        else $error("Soft reset without a control write");
    AST_PIN_RESET: assert property (!reset_n |-> ##[1:4] !clk_stable_o)
        else $error("Pin reset did not restart the lock");
    AST_LOCK_WAIT: assert property ($rose(clk_stable_o) |->
        $past(reset_n, 2) && $past(reset_n, 3))
        else $error("Clock stable before the lock time");
endmodule // hbrp_checker

// ==== sim/hbrp_test.sv ====
`timescale 1ns/1ps
`include "hbrp_map.svh"
module hbrp_test;
    import hbrp_pkg::*;
    // Clock, reset, supply good and host user port
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        por_ok_i = 1'b0;
    logic        req_i = 1'b0;
    logic        req_wr_i = 1'b0;
    logic [7:0]  req_addr_i = 8'h00;
    logic [15:0] req_wdata_i = 16'h0000;
    logic        hwrst_i = 1'b0;
    logic        busy_o, done_o, clk_stable_o, swrst_o, wr_stb_o;
    logic        bad_stable, bad_stb;
    logic [15:0] rdata_o;
    logic [7:0]  wr_addr_o;
    logic [7:0]  addrs [5] = '{8'h00, 8'h01, 8'h7f, 8'hff, 8'h21};
    logic [15:0] datas [5] = '{16'ha5a5, 16'h5a5a, 16'hffff, 16'h0001,
                               16'h8000};
    int          fails = 0;
    int          checked = 0;
    int          commits = 0;
    int          resets = 0;
    int          bad_commits = 0;
    int          n;

    hbrp_if bif ();
    hbrp_if bif2 ();

    always #25 mclk_i = ~mclk_i;

    // Pulses counted from values settled before each edge
    always @(posedge mclk_i)
    begin
        if (wr_stb_o === 1'b1)
            commits++;
        if (swrst_o === 1'b1)
            resets++;
        if (bad_stb === 1'b1)
            bad_commits++;
    end

    hbrp_host u_hbrp_host (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .hb(bif.host),
        .req_i(req_i), .req_wr_i(req_wr_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .hwrst_i(hwrst_i), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata_o));
    hbrp_dev u_hbrp_dev (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .hb(bif.dev),
        .por_ok_i(por_ok_i), .clk_stable_o(clk_stable_o),
        .swrst_o(swrst_o), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o));
    // Second device faced by a bench driver that breaks the host rules
    hbrp_dev u_hbrp_dev2 (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hb(bif2.dev),
        .por_ok_i(por_ok_i), .clk_stable_o(bad_stable), .swrst_o(),
        .wr_stb_o(bad_stb), .wr_addr_o());
    hbrp_checker u_hbrp_checker (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n(bif.cs_n),
        .rd_n(bif.rd_n), .wr_n(bif.wr_n), .reset_n(bif.reset_n),
        .host_doe(bif.host_doe), .dev_doe(bif.dev_doe),
        .clk_stable_o(clk_stable_o), .swrst_o(swrst_o),
        .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o));

    // Advance n edges, landing just after the last one
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #2;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        check(16'h0000, 16'h0001);
        print_verdict();
    endtask

    // Bounded waits: a hang counts as a mismatch and ends the run
    task automatic wait_done();
        for (int i = 0; i < 40 && done_o !== 1'b1; i++)
            tick(1);
        if (done_o !== 1'b1)
            timeout();
    endtask

    task automatic wait_stable(input logic v, output int cyc);
        for (cyc = 0; cyc < 40 && clk_stable_o !== v; cyc++)
            tick(1);
        if (clk_stable_o !== v)
            timeout();
    endtask

    // One bus access through the host end; request held one edge
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [15:0] d);
        req_i = 1'b1;
        req_wr_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        tick(1);
        req_i = 1'b0;
        check(16'(busy_o), 16'h0001);
        wait_done();
        check(16'(busy_o), 16'h0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        access(1'b0, a, 16'h0000);
        check(rdata_o, exp);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        bif2.adrs = 8'h05;
        bif2.cs_n = 1'b1;
        bif2.rd_n = 1'b1;
        bif2.wr_n = 1'b1;
        bif2.reset_n = 1'b1;
        bif2.test = 1'b0;
        bif2.host_dout = 16'hbeef;
        bif2.host_doe = 1'b0;
        tick(2);
        rstn_i = 1'b1;
        // Supply below threshold keeps the lock from starting
        tick(10);
        check(16'(clk_stable_o), 16'h0000);
        por_ok_i = 1'b1;
        wait_stable(1'b1, n);
        check(16'(n >= `HBRP_LOCK_CYC + 2), 16'h0001);
        check(16'(bif.test), 16'h0000);
        // Back-to-back writes over a spread of halfwords, then read back
        for (n = 0; n < 5; n++)
            access(1'b1, addrs[n], datas[n]);
        check({8'h00, wr_addr_o}, 16'h0021);
        for (n = 0; n < 5; n++)
            rd(addrs[n], datas[n]);
        check(16'(commits), 16'h0005);
        check(bif.data, `HBRP_BUS_IDLE);
        // Bit 0 clear stores plainly; bit 0 set clears everything
        access(1'b1, `HBRP_SWCTL_ADDR, 16'h0002);
        rd(`HBRP_SWCTL_ADDR, 16'h0002);
        check(16'(resets), 16'h0000);
        access(1'b1, `HBRP_SWCTL_ADDR, 16'h0003);
        tick(3);
        check(16'(resets), 16'h0001);
        rd(`HBRP_SWCTL_ADDR, 16'h0000);
        for (n = 0; n < 5; n++)
            rd(addrs[n], `HBRP_REG_DEFAULT);
        // Pin reset restarts the lock but keeps stored words
        access(1'b1, 8'h05, 16'h1234);
        hwrst_i = 1'b1;
        tick(1);
        hwrst_i = 1'b0;
        wait_done();
        wait_stable(1'b0, n);
        wait_stable(1'b1, n);
        check(16'(n >= `HBRP_LOCK_CYC), 16'h0001);
        rd(8'h05, 16'h1234);
        // Clock enable low freezes both ends: the request is not taken
        ce_i = 1'b0;
        req_i = 1'b1;
        req_wr_i = 1'b1;
        tick(4);
        check(16'(busy_o), 16'h0000);
        req_i = 1'b0;
        ce_i = 1'b1;
        tick(2);
        check(16'(commits), 16'h0008);
        // Far end lowers both strobes with data driven: refused
        check(16'(bad_stable), 16'h0001);
        bif2.cs_n = 1'b0;
        bif2.rd_n = 1'b0;
        bif2.wr_n = 1'b0;
        bif2.host_doe = 1'b1;
        tick(8);
        check(16'(bif2.dev_doe), 16'h0000);
        bif2.cs_n = 1'b1;
        bif2.rd_n = 1'b1;
        bif2.wr_n = 1'b1;
        bif2.host_doe = 1'b0;
        tick(6);
        check(16'(bad_commits), 16'h0000);
        print_verdict();
    end
endmodule // hbrp_test
